// >>> dfc_cmd_core.sv
// Command capture, two-part decode, mode registers, power-down and self-refresh control.
// Assumes command pins are driven by a controller on the same clock; the power-down pin may rise at any time.
`timescale 1ns/1ps

module dfc_cmd_core (
  input  wire logic                        clk,             // Device clock, rising edge.
  input  wire logic                        rstn,            // Synchronous reset, active low.
  input  wire logic                        cs_n,            // Chip select, active low.
  input  wire logic                        function_select, // Read-open high, write-open low.
  input  wire logic [dfc_pkg::BANK_W-1:0]  bank,            // Bank select.
  input  wire logic [dfc_pkg::ADDR_W-1:0]  addr,            // Address A14 to A0.
  input  wire logic                        power_down_n,    // Power-down pin, active low.
  output logic                             rd_stb,          // Read decoded, one cycle.
  output logic                             wr_stb,          // Write decoded, one cycle.
  output logic                             ref_stb,         // Auto-refresh decoded, one cycle.
  output logic                             mode_stb,        // Mode load taken, one cycle.
  output logic                             ext_stb,         // Extended mode load taken, one cycle.
  output logic                             wlen_reserved,   // Reserved write length code, one cycle.
  output logic [dfc_pkg::BANK_W-1:0]       acc_bank,        // Bank of the current access.
  output logic [dfc_pkg::ADDR_W-1:0]       row_part_address,    // Row part of the access.
  output logic [dfc_pkg::COL_W-1:0]        column_part_address, // Column part of the access.
  output logic [2:0]                       write_words,     // Words stored by the last write.
  output logic [dfc_pkg::MR_W-1:0]         mode_reg,        // Mode register contents.
  output logic [dfc_pkg::MR_W-1:0]         ext_mode_reg,    // Extended mode register contents.
  output logic                             dll_on,          // Delay-locked loop enabled.
  output logic                             ready,           // Normal operation allowed.
  output logic                             ref_pace_err,    // Refresh too dense, one cycle.
  output logic                             in_power_down,   // Power-down state.
  output logic                             in_self_refresh, // Self-refresh state.
  output logic                             input_active,    // Input buffers awake.
  output logic                             dq_oe            // Data output enable.
);
  localparam int CNT_W = 4;

  dfc_init_if link ();

  dfc_pkg::dfc_state_t state, next_state;

  logic                       cs_q, fn_q, pd_q;
  logic [dfc_pkg::BANK_W-1:0] ba_q;
  logic [dfc_pkg::ADDR_W-1:0] a_q;
  logic                       next_rd, next_wr, next_ref, next_mode, next_ext, next_rsv;
  logic [dfc_pkg::BANK_W-1:0] next_bank;
  logic [dfc_pkg::ADDR_W-1:0] next_row;
  logic [dfc_pkg::COL_W-1:0]  next_col;
  logic [2:0]                 next_words;
  logic [dfc_pkg::MR_W-1:0]   next_mr, next_emr;
  logic [CNT_W-1:0]           rd_cnt, next_rd_cnt;
  logic                       next_oe;
  logic                       burst4;
  logic [2:0]                 read_latency;
  logic [CNT_W-1:0]           burst_cyc;
  logic                       mr_addr_ok;

  // Pins are captured once on the rising edge before any decode looks at them.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      cs_q <= 1'b1;
      fn_q <= 1'b0;
      pd_q <= 1'b1;
      ba_q <= '0;
      a_q  <= '0;
    end
    else
    begin
      cs_q <= cs_n;
      fn_q <= function_select;
      pd_q <= power_down_n;
      ba_q <= bank;
      a_q  <= addr;
    end
  end

  assign burst4       = mode_reg[dfc_pkg::MR_BL_BIT];
  assign read_latency = mode_reg[dfc_pkg::MR_CL_LSB +: 3];
  assign burst_cyc    = burst4 ? 4'h2 : 4'h1;
  assign mr_addr_ok   = a_q[dfc_pkg::MR_ZERO_MSB:dfc_pkg::MR_ZERO_LSB] == '0;

  always_comb
  begin
    next_state = state;
    next_rd    = 1'b0;
    next_wr    = 1'b0;
    next_ref   = 1'b0;
    next_mode  = 1'b0;
    next_ext   = 1'b0;
    next_rsv   = 1'b0;
    next_bank  = acc_bank;
    next_row   = row_part_address;
    next_col   = column_part_address;
    next_words = write_words;
    next_mr    = mode_reg;
    next_emr   = ext_mode_reg;
    case (state)
      dfc_pkg::ST_IDLE:
        if (!pd_q)
          next_state = cs_q ? dfc_pkg::ST_PDOWN : dfc_pkg::ST_IDLE;
        else if (!cs_q)
        begin
          next_state = fn_q ? dfc_pkg::ST_ROW_RD : dfc_pkg::ST_ROW_WR;
          next_bank  = ba_q;
          next_row   = a_q;
        end
      dfc_pkg::ST_ROW_RD:
      begin
        next_state = dfc_pkg::ST_IDLE;
        if (cs_q)
        begin
          next_rd  = 1'b1;
          next_col = a_q[dfc_pkg::COL_W-1:0];
        end
        else if (mr_addr_ok)
        begin
          if (ba_q == dfc_pkg::MR_SEL_EXT)
          begin
            next_ext = 1'b1;
            next_emr = {ba_q, a_q[7:0]};
          end
          else
          begin
            next_mode = 1'b1;
            next_mr   = {ba_q, a_q[7:0]};
          end
        end
      end
      dfc_pkg::ST_ROW_WR:
      begin
        next_state = dfc_pkg::ST_IDLE;
        if (cs_q)
        begin
          next_wr    = 1'b1;
          next_col   = a_q[dfc_pkg::COL_W-1:0];
          next_words = dfc_pkg::wlen_words(burst4, a_q[dfc_pkg::WLEN_B0_BIT], a_q[dfc_pkg::WLEN_B1_BIT]);
          next_rsv   = next_words == 3'h0;
        end
        else
        begin
          next_ref = 1'b1;
          if (!pd_q)
            next_state = dfc_pkg::ST_SELF;
        end
      end
      dfc_pkg::ST_PDOWN, dfc_pkg::ST_SELF:
        if (pd_q && cs_q)
          next_state = dfc_pkg::ST_IDLE;
      default:
        next_state = dfc_pkg::ST_IDLE;
    endcase
  end

  // Read bursts drive the data pins only after read latency and never before ready.
  always_comb
  begin
    next_rd_cnt = (rd_cnt != '0) ? rd_cnt - 1'b1 : rd_cnt;
    if (next_rd && ready)
      next_rd_cnt = CNT_W'(read_latency) + burst_cyc;
    next_oe = ready && next_rd_cnt != '0 && next_rd_cnt <= burst_cyc;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      state               <= dfc_pkg::ST_IDLE;
      rd_stb              <= 1'b0;
      wr_stb              <= 1'b0;
      ref_stb             <= 1'b0;
      mode_stb            <= 1'b0;
      ext_stb             <= 1'b0;
      wlen_reserved       <= 1'b0;
      acc_bank            <= '0;
      row_part_address    <= '0;
      column_part_address <= '0;
      write_words         <= 3'h0;
      mode_reg            <= dfc_pkg::MR_RST;
      ext_mode_reg        <= dfc_pkg::EMR_RST;
      rd_cnt              <= '0;
      dq_oe               <= 1'b0;
    end
    else
    begin
      state               <= next_state;
      rd_stb              <= next_rd;
      wr_stb              <= next_wr;
      ref_stb             <= next_ref;
      mode_stb            <= next_mode;
      ext_stb             <= next_ext;
      wlen_reserved       <= next_rsv;
      acc_bank            <= next_bank;
      row_part_address    <= next_row;
      column_part_address <= next_col;
      write_words         <= next_words;
      mode_reg            <= next_mr;
      ext_mode_reg        <= next_emr;
      rd_cnt              <= next_rd_cnt;
      dq_oe               <= next_oe;
    end
  end

  assign link.ext_load  = ext_stb;
  assign link.mode_load = mode_stb;
  assign link.refresh   = ref_stb;
  assign ready          = link.ready;
  assign ref_pace_err   = link.ref_err;
  assign dll_on         = ext_mode_reg[dfc_pkg::EMR_DLL_BIT];
  assign in_power_down  = state == dfc_pkg::ST_PDOWN;
  assign in_self_refresh = state == dfc_pkg::ST_SELF;
  // Wake-up follows the pin directly so exit does not wait for a clock edge.
  assign input_active   = !(in_power_down || in_self_refresh) || (power_down_n && cs_n);

  dfc_init_tracker #(
    .HIST (dfc_pkg::REF_WIN_CNT)
  ) u_trk (
    .clk  (clk),
    .rstn (rstn),
    .link (link)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  chk_dq_quiet: assert property (!ready |-> !dq_oe)
    else $error("data output enabled before ready");
  chk_cmd_capture: assert property ((state == dfc_pkg::ST_IDLE && !cs_q && pd_q) |=>
    ((state == dfc_pkg::ST_ROW_RD) || (state == dfc_pkg::ST_ROW_WR)) && acc_bank == $past(ba_q))
    else $error("first command not captured");
  chk_pair_next: assert property ((state == dfc_pkg::ST_ROW_RD || state == dfc_pkg::ST_ROW_WR) |=>
    (state == dfc_pkg::ST_IDLE || state == dfc_pkg::ST_SELF))
    else $error("second command not taken on next clock");
  chk_read_decode: assert property ((state == dfc_pkg::ST_ROW_RD && cs_q) |=>
    rd_stb && !mode_stb && column_part_address == $past(a_q[dfc_pkg::COL_W-1:0]))
    else $error("read pair misdecoded");
  chk_ref_decode: assert property ((state == dfc_pkg::ST_ROW_WR && !cs_q) |=> ref_stb && !wr_stb)
    else $error("refresh pair misdecoded");
  chk_wlen_bl2: assert property ((state == dfc_pkg::ST_ROW_WR && cs_q && !burst4 && a_q[14]) |=>
    wr_stb && write_words == 3'h1)
    else $error("burst two write length wrong");
  chk_wlen_bl4: assert property ((state == dfc_pkg::ST_ROW_WR && cs_q && burst4 && a_q[14:13] == 2'b01) |=>
    write_words == 3'h2 && !wlen_reserved)
    else $error("burst four write length wrong");
  chk_mode_guard: assert property ((state == dfc_pkg::ST_ROW_RD && !cs_q && !mr_addr_ok) |=>
    !mode_stb && !ext_stb && $stable(mode_reg))
    else $error("mode load accepted with high address bits");
  chk_async_exit: assert property ((in_self_refresh || in_power_down) && power_down_n && cs_n |-> input_active)
    else $error("exit waited for a clock edge");

  cov_read: cover property (rd_stb ##[1:20] dq_oe);
  cov_write: cover property (wr_stb && write_words == 3'h1);
  cov_self: cover property (in_self_refresh ##[1:50] !in_self_refresh);
  cov_ready: cover property ($rose(ready));

endmodule // dfc_cmd_core

// >>> dfc_pkg.sv
// Shared constants, state encoding and decode helpers for the two-part command device logic.
// Assumes a single clock at 25 MHz that stands for the rising crossing of the differential clock.
package dfc_pkg;

  localparam int CLK_PERIOD_NS  = 40;
  localparam int DLL_LOCK_CLKS  = 200;
  localparam int INIT_REF_MIN   = 2;
  localparam int REF_MIN_AVG_NS = 400;
  localparam int REF_WIN_CNT    = 8;
  localparam int REF_WIN_NS     = REF_WIN_CNT * REF_MIN_AVG_NS;
  localparam int REF_WIN_CYC    = (REF_WIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int BANK_W = 2;
  localparam int ADDR_W = 15;
  localparam int COL_W  = 7;
  localparam int MR_W   = 10;

  localparam int WLEN_B0_BIT  = 14;
  localparam int WLEN_B1_BIT  = 13;
  localparam int MR_ZERO_MSB  = 14;
  localparam int MR_ZERO_LSB  = 8;

  localparam logic [BANK_W-1:0] MR_SEL_BASE = 2'h0;
  localparam logic [BANK_W-1:0] MR_SEL_EXT  = 2'h1;

  localparam int MR_BL_BIT    = 0;
  localparam int MR_BT_BIT    = 3;
  localparam int MR_CL_LSB    = 4;
  localparam int EMR_DLL_BIT  = 0;
  localparam int EMR_DRV_BIT  = 1;
  localparam int EMR_STRB_BIT = 2;

  localparam logic [MR_W-1:0] MR_RST  = 10'h000;
  localparam logic [MR_W-1:0] EMR_RST = 10'h000;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ROW_RD = 3'b001,
    ST_ROW_WR = 3'b010,
    ST_PDOWN  = 3'b011,
    ST_SELF   = 3'b100
  } dfc_state_t;

  // Number of words a write really stores; zero marks the reserved code.
  function automatic logic [2:0] wlen_words(input logic burst4, input logic b0, input logic b1);
    if (!burst4)
      wlen_words = b0 ? 3'h1 : 3'h2;
    else
      case ({b0, b1})
        2'b10:   wlen_words = 3'h4;
        2'b01:   wlen_words = 3'h2;
        2'b11:   wlen_words = 3'h1;
        default: wlen_words = 3'h0;
      endcase
  endfunction

endpackage

// >>> dfc_init_if.sv
// Links the command decoder with the initialisation and refresh tracker.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface dfc_init_if;
  logic ext_load;
  logic mode_load;
  logic refresh;
  logic ready;
  logic ref_err;
  modport main (output ext_load, output mode_load, output refresh, input ready, input ref_err);
  modport trk  (input ext_load, input mode_load, input refresh, output ready, output ref_err);
endinterface

// >>> dfc_init_tracker.sv
// Tracks the power-up sequence and flags auto-refresh operations that come too close together.
// Assumes one-cycle event pulses from the command decoder on the same clock.
`timescale 1ns/1ps
module dfc_init_tracker #(
  parameter int HIST = dfc_pkg::REF_WIN_CNT
) (
  input wire logic clk,  // Device clock.
  input wire logic rstn, // Synchronous reset, active low.
  dfc_init_if.trk  link  // Events in, readiness out.
);
  localparam int DLL_W = $clog2(dfc_pkg::DLL_LOCK_CLKS + 1);
  localparam int AGE_W = $clog2(dfc_pkg::REF_WIN_CYC + 1);
  localparam logic [DLL_W-1:0] DLL_END = DLL_W'(dfc_pkg::DLL_LOCK_CLKS);
  localparam logic [AGE_W-1:0] AGE_MAX = AGE_W'(dfc_pkg::REF_WIN_CYC);
  localparam logic [1:0]       REF_MIN = 2'(dfc_pkg::INIT_REF_MIN);

  logic             ext_seen, next_ext_seen;
  logic             mode_seen, next_mode_seen;
  logic             ready, next_ready;
  logic             err, next_err;
  logic [1:0]       ref_cnt, next_ref_cnt;
  logic [DLL_W-1:0] dll_cnt, next_dll_cnt;
  logic [AGE_W-1:0] age [HIST];
  logic [AGE_W-1:0] next_age [HIST];
  logic [HIST-1:0]  vld, next_vld;
  logic [DLL_W-1:0] gap, next_gap;

  always_comb
  begin
    next_ext_seen  = ext_seen | link.ext_load;
    next_mode_seen = mode_seen | link.mode_load;
    next_ref_cnt   = (link.refresh && ref_cnt != REF_MIN) ? ref_cnt + 2'h1 : ref_cnt;
    next_dll_cnt   = dll_cnt;
    if (link.ext_load && !ready)
      next_dll_cnt = '0;
    else if (ext_seen && dll_cnt != DLL_END)
      next_dll_cnt = dll_cnt + 1'b1;
    next_ready = ready | (ext_seen && mode_seen && ref_cnt == REF_MIN && dll_cnt == DLL_END);
    next_vld   = link.refresh ? {vld[HIST-2:0], 1'b1} : vld;
    for (int i = 0; i < HIST; i++)
      next_age[i] = (age[i] == AGE_MAX) ? age[i] : age[i] + 1'b1;
    // A refresh shifts the history so the entry at the end is the eighth one back.
    if (link.refresh)
    begin
      next_age[0] = '0;
      for (int i = 1; i < HIST; i++)
        next_age[i] = age[i-1];
    end
    next_err = link.refresh && vld[HIST-1] && age[HIST-1] < AGE_MAX;
  end

  // Cycles since the last extended mode load, counted apart from the lock counter.
  always_comb
  begin
    next_gap = gap;
    if (link.ext_load)
      next_gap = '0;
    else if (gap != '1)
      next_gap = gap + 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      gap <= '0;
    else
      gap <= next_gap;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      ext_seen  <= 1'b0;
      mode_seen <= 1'b0;
      ready     <= 1'b0;
      err       <= 1'b0;
      ref_cnt   <= 2'h0;
      dll_cnt   <= '0;
      vld       <= '0;
      for (int i = 0; i < HIST; i++)
        age[i] <= '0;
    end
    else
    begin
      ext_seen  <= next_ext_seen;
      mode_seen <= next_mode_seen;
      ready     <= next_ready;
      err       <= next_err;
      ref_cnt   <= next_ref_cnt;
      dll_cnt   <= next_dll_cnt;
      vld       <= next_vld;
      age       <= next_age;
    end
  end

  assign link.ready   = ready;
  assign link.ref_err = err;

  chk_ready_delay: assert property (@(posedge clk) disable iff (!rstn)
    (link.ext_load && !ready) |=> !ready [*8])
    else $error("ready rose too soon after extended mode load");
  chk_ready_gap: assert property (@(posedge clk) disable iff (!rstn)
    $rose(ready) |-> gap >= DLL_END)
    else $error("ready rose before the lock count ran out");

endmodule // dfc_init_tracker

// >>> dfc_ctl_model.sv
// Behavioural memory controller that drives the two-part command pins.
// Assumes one bench process calls its tasks, all on the rising edge of clk.
`timescale 1ns/1ps
module dfc_ctl_model (
  input  wire logic                       clk,             // Device clock.
  output logic                            cs_n,            // Chip select, active low.
  output logic                            function_select, // First command kind.
  output logic [dfc_pkg::BANK_W-1:0]      bank,            // Bank select.
  output logic [dfc_pkg::ADDR_W-1:0]      addr,            // Address A14 to A0.
  output logic                            power_down_n     // Power-down pin, active low.
);
  initial
  begin
    cs_n = 1'h1;
    function_select = 1'h0;
    bank = 2'h0;
    addr = 15'h0000;
    power_down_n = 1'h1;
  end

  // Deselected lines keep moving so a stale value is never mistaken for a command.
  task automatic idle_pins(input logic pd);
    cs_n <= 1'h1;
    function_select <= ~function_select;
    bank <= ~bank;
    addr <= ~addr;
    power_down_n <= pd;
  endtask

  task automatic power_up();
    repeat (5000) @(posedge clk);
    idle_pins(1'h1);
  endtask

  task automatic pair(input logic fn, input logic cs2, input logic pd2,
                      input logic [1:0] ba, input logic [14:0] a1, input logic [14:0] a2);
    @(posedge clk);
    cs_n <= 1'h0;
    function_select <= fn;
    bank <= ba;
    addr <= a1;
    power_down_n <= 1'h1;
    @(posedge clk);
    cs_n <= cs2;
    addr <= a2;
    power_down_n <= pd2;
    @(posedge clk);
    idle_pins(pd2);
  endtask

  task automatic sleep(input logic pd);
    @(posedge clk);
    power_down_n <= pd;
  endtask
endmodule // dfc_ctl_model

// >>> tb_top.sv
// Self-checking bench for the command core, driven through the controller model.
// Assumes the core's stated latencies: strobes appear two edges after the second command.
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic cs_n, fs, pd, rd_stb, wr_stb, ref_stb, mode_stb, ext_stb, wres, dll_on, ready, perr, in_pd, in_sr, ia, dq_oe;
  logic [1:0] ba, acc_bank;
  logic [14:0] a, row;
  logic [6:0] col;
  logic [2:0] ww;
  logic [9:0] mr, emr;
  int n_mismatch = 0;
  int num_checks = 0;
  int n_ref, n_perr, n_dq, i;
  logic [2:0] ww4 [4] = '{3'h0, 3'h2, 3'h4, 3'h1};
  logic [1:0] v;

  always #20 clk = ~clk;

  dfc_ctl_model u_ctl (.clk(clk), .cs_n(cs_n), .function_select(fs), .bank(ba), .addr(a), .power_down_n(pd));

  dfc_cmd_core u_dut (.clk(clk), .rstn(rstn), .cs_n(cs_n), .function_select(fs), .bank(ba), .addr(a),
    .power_down_n(pd), .rd_stb(rd_stb), .wr_stb(wr_stb), .ref_stb(ref_stb), .mode_stb(mode_stb),
    .ext_stb(ext_stb), .wlen_reserved(wres), .acc_bank(acc_bank), .row_part_address(row),
    .column_part_address(col), .write_words(ww), .mode_reg(mr), .ext_mode_reg(emr), .dll_on(dll_on),
    .ready(ready), .ref_pace_err(perr), .in_power_down(in_pd), .in_self_refresh(in_sr),
    .input_active(ia), .dq_oe(dq_oe));

  always @(posedge clk)
  begin
    if (ref_stb === 1'h1) n_ref++;
    if (perr === 1'h1) n_perr++;
    if (dq_oe === 1'h1) n_dq++;
  end

  task automatic chk(input logic [14:0] seen, input logic [14:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    #400000;
    n_mismatch++;
    print_verdict();
  end

  initial
  begin
    repeat (16) @(posedge clk);
    rstn <= 1'h1;
    step(1);
    chk(ready, 15'h0);
    chk(dq_oe, 15'h0);
    chk(ia, 15'h1);
    u_ctl.power_up();
    u_ctl.pair(1'h1, 1'h0, 1'h1, 2'h0, 15'h0000, 15'h0041);
    step(1);
    chk(mode_stb, 15'h1);
    chk(mr, 15'h0041);
    u_ctl.pair(1'h1, 1'h0, 1'h1, 2'h0, 15'h0000, 15'h01ff);
    step(1);
    chk(mode_stb, 15'h0);
    chk(mr, 15'h0041);
    repeat (2)
    begin
      u_ctl.pair(1'h0, 1'h0, 1'h1, 2'h0, 15'h0000, 15'h0000);
      step(1);
      chk(ref_stb, 15'h1);
    end
    u_ctl.pair(1'h1, 1'h0, 1'h1, 2'h1, 15'h0000, 15'h0007);
    step(1);
    chk(ext_stb, 15'h1);
    chk(emr, 15'h0107);
    chk(dll_on, 15'h1);
    u_ctl.pair(1'h1, 1'h1, 1'h1, 2'h2, 15'h1234, 15'h0055);
    step(1);
    chk(rd_stb, 15'h1);
    chk(col, 15'h0055);
    chk(acc_bank, 15'h2);
    chk(row, 15'h1234);
    n_dq = 0;
    step(12);
    chk(n_dq[14:0], 15'h0);
    step(183);
    chk(ready, 15'h0);
    i = 0;
    while (ready !== 1'h1 && i < 10)
    begin
      step(1);
      i++;
    end
    chk(ready, 15'h1);
    $display("test init done");
    n_dq = 0;
    u_ctl.pair(1'h1, 1'h1, 1'h1, 2'h0, 15'h0100, 15'h0011);
    step(14);
    chk(n_dq[14:0], 15'h2);
    for (int c = 0; c < 4; c++)
    begin
      v = c[1:0];
      u_ctl.pair(1'h0, 1'h1, 1'h1, 2'h3, 15'h0abc, {v, 13'h0011});
      step(1);
      chk(wr_stb, 15'h1);
      chk(ww, ww4[v]);
      chk(wres, (v == 2'h0));
    end
    u_ctl.pair(1'h1, 1'h0, 1'h1, 2'h0, 15'h0000, 15'h0040);
    step(1);
    chk(mr, 15'h0040);
    for (int j = 0; j < 2; j++)
    begin
      u_ctl.pair(1'h0, 1'h1, 1'h1, 2'h1, 15'h0001, {j[0], 14'h2011});
      step(1);
      chk(ww, j ? 15'h1 : 15'h2);
    end
    $display("test access done");
    step(100);
    n_ref = 0;
    n_perr = 0;
    repeat (9) u_ctl.pair(1'h0, 1'h0, 1'h1, 2'h0, 15'h0000, 15'h0000);
    step(3);
    chk(n_ref[14:0], 15'h9);
    chk(n_perr[14:0], 15'h1);
    $display("test refresh done");
    step(100);
    u_ctl.sleep(1'h0);
    step(2);
    chk(in_pd, 15'h1);
    chk(ia, 15'h0);
    u_ctl.sleep(1'h1);
    #1;
    chk(ia, 15'h1);
    step(3);
    chk(in_pd, 15'h0);
    $display("test power down done");
    u_ctl.pair(1'h0, 1'h0, 1'h0, 2'h0, 15'h0000, 15'h0000);
    step(1);
    chk(ref_stb, 15'h1);
    step(2);
    chk(in_sr, 15'h1);
    chk(ia, 15'h0);
    u_ctl.sleep(1'h1);
    #1;
    chk(ia, 15'h1);
    step(3);
    chk(in_sr, 15'h0);
    $display("test self refresh done");
    print_verdict();
  end
endmodule // tb_top
